//--- verilog/decim_pkg.sv
package decim_pkg;

    // Register byte addresses on the AHB-Lite bus.
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;

    // Configuration field positions and status bit positions.
    localparam int CFG_RATIO_LSB = 0;
    localparam int CFG_PWR_LSB = 3;
    localparam int CFG_CLKSEL_BIT = 5;
    localparam int CFG_STANDBY_BIT = 6;
    localparam int ST_FAST_BIT = 0;
    localparam int ST_OVF_BIT = 1;
    localparam int ST_AVAIL_BIT = 2;
    localparam int ST_LEVEL_LSB = 8;

    // Filter geometry: log2 of the smallest ratio, sinc3 ratio cap, output scale.
    localparam int OSR_MIN_LOG = 7;
    localparam int N3_MAX_SEL = 3;
    localparam int FS_BITS = 16;
    localparam int WORD_W = FS_BITS + 1;
    localparam int MOD_DIV = 2;

    typedef enum logic [1:0] {
        PWR_HR = 2'b00,
        PWR_LP = 2'b01,
        PWR_VLP = 2'b10
    } pwr_e;

    typedef struct packed {
        logic standby;
        logic clk_sel;
        logic [1:0] pwr;
        logic [2:0] ratio;
    } cfg_s;

    localparam cfg_s CFG_RST = 7'h00;
    localparam logic [2:0] DIV_HR = 3'h1;
    localparam logic [2:0] DIV_LP = 3'h2;
    localparam logic [2:0] DIV_VLP = 3'h4;

endpackage

//--- verilog/decim_filter.sv
// Operation
// RQ1: Host enters standby before switching the main clock source.
// RQ2: Host enters standby before changing the power mode.
// RQ3: With oscillator only, host ties external clock pin to ground.
// RQ4: Modulator clock runs at half the main clock, one bit per tick.
// RQ5: Sinc low-pass averages the stream; word rate is modulator rate over ratio.
// RQ6: Three-bit field selects one of eight ratios from 128 to 16384.
// RQ7: Output rate scales with main clock and halves per ratio doubling.
// RQ8: Stream feeds a sinc3 path and a first-order fast path in parallel.
// RQ9: First conversions after reset come from the fast path.
// RQ10: After two fast conversions, sinc3 path is used until reset.
// RQ11: Above 1024, sinc3 runs at 1024 then sinc1 decimates by 2 to 16.
// RQ12: Power modes select clock divider 1, 2 or 4.
// RQ13: Ratio codes 0 to 7 select 128 to 16384 ascending.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module sync_fifo
#(
    parameter int W = 17,
    parameter int DEPTH = 8
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire logic push = ce && in_valid && in_ready;
    wire logic pop = ce && out_valid && out_ready;

    assign in_ready = cnt_q != (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data = mem[rp_q];
    assign count = cnt_q;

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wp_q] <= in_data;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module decim_filter
    import decim_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
)
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic MOD_BIT,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output logic MOD_CLK,
    output logic CLK_SRC_SEL,
    output logic [1:0] PWR_MODE,
    output logic [2:0] CLK_DIV,
    output logic FAST_PATH,
    output logic DATA_VALID
);
    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    cfg_s cfg_q;
    logic mod_ph_q;
    logic [13:0] samp_q;
    logic [31:0] i1_q, i2_q, i3_q, z1_q, z2_q, z3_q;
    logic [20:0] acc_q;
    logic [14:0] ones_q;
    logic fast_q, first_q, ovf_q;
    logic [2:0] div_q;
    logic dv_q, hready_q, rd_pend_q, wr_pend_q;
    logic [7:0] addr_q;
    logic [31:0] hrdata_q;
    logic fifo_in_ready, fifo_out_valid;
    logic [WORD_W-1:0] fifo_out_data;
    logic [CW-1:0] fifo_count;

    ////////////////////////////////////////////////////////////////////////////
    // Modulator tick and ratio decode.
    wire logic run = CLK_EN && mod_ph_q && !cfg_q.standby; // RQ4
    wire logic [2:0] ratio = cfg_q.ratio;
    wire logic [14:0] osr = 15'h0080 << ratio; // RQ6 RQ13
    wire logic [13:0] osr_m1 = 14'(osr - 15'h0001);
    wire logic [1:0] n3_sh = (ratio > 3'(N3_MAX_SEL)) ? 2'(N3_MAX_SEL) : ratio[1:0]; // RQ11
    wire logic [9:0] n3_mask = 10'((11'h0080 << n3_sh) - 11'h0001);
    wire logic [2:0] d_log = (ratio > 3'(N3_MAX_SEL)) ? ratio - 3'(N3_MAX_SEL) : 3'h0; // RQ11
    wire logic n3_end = &(samp_q[9:0] | ~n3_mask);
    wire logic conv_end = samp_q == osr_m1; // RQ5 RQ7

    ////////////////////////////////////////////////////////////////////////////
    // Sinc3 path. Wrapping two's complement arithmetic keeps the combs exact.
    wire logic [31:0] i1_d = i1_q + {31'h0000_0000, MOD_BIT}; // RQ8
    wire logic [31:0] i2_d = i2_q + i1_d;
    wire logic [31:0] i3_d = i3_q + i2_d;
    wire logic [31:0] y1 = i3_d - z1_q;
    wire logic [31:0] y2 = y1 - z2_q;
    wire logic [31:0] y3 = y2 - z3_q; // RQ5
    wire logic [4:0] sh3 = {2'b00, n3_sh, 1'b0} + {3'b000, n3_sh} + 5'h05;
    wire logic [WORD_W-1:0] s3 = WORD_W'(y3 >> sh3);
    wire logic [20:0] acc_d = acc_q + {4'h0, s3}; // RQ11
    wire logic [WORD_W-1:0] sinc_out = WORD_W'(acc_d >> d_log);

    // Fast path: a plain ones count over the whole ratio, scaled to full scale.
    wire logic [14:0] ones_d = ones_q + {14'h0000, MOD_BIT}; // RQ8
    wire logic [3:0] fsh = 4'h9 - {1'b0, ratio};
    wire logic [WORD_W-1:0] fast_out = WORD_W'({2'b00, ones_d} << fsh);

    wire logic conv_push = run && conv_end;
    wire logic [WORD_W-1:0] word = fast_q ? fast_out : sinc_out; // RQ9 RQ10

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode.
    wire logic acc = CLK_EN && HSEL && HTRANS[1] && HREADY;
    wire logic rd_acc = acc && !HWRITE;
    wire logic wr_cfg = CLK_EN && wr_pend_q && addr_q == ADDR_CFG;
    wire logic wr_st = CLK_EN && wr_pend_q && addr_q == ADDR_STATUS;
    wire logic pop = CLK_EN && rd_pend_q && addr_q == ADDR_DATA;
    wire logic [31:0] st_word = {16'h0000, 8'(fifo_count), 5'h00,
                                 fifo_out_valid, ovf_q, fast_q};
    wire logic [31:0] rdata = (addr_q == ADDR_CFG) ? {25'h000_0000, cfg_q} :
                              (addr_q == ADDR_STATUS) ? st_word :
                              (addr_q == ADDR_DATA) ? 32'(fifo_out_data) : 32'h0000_0000;
    wire logic [2:0] div_d = (cfg_q.pwr == PWR_VLP) ? DIV_VLP :
                             (cfg_q.pwr == PWR_LP) ? DIV_LP : DIV_HR; // RQ12

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            mod_ph_q <= 1'b0;
        else if (CLK_EN)
            mod_ph_q <= !mod_ph_q; // RQ4
    end

    // Standby restarts the conversion but keeps the path selection.
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            samp_q <= '0;
            i1_q <= '0;
            i2_q <= '0;
            i3_q <= '0;
            ones_q <= '0;
        end
        else if (CLK_EN && cfg_q.standby)
        begin
            samp_q <= '0;
            i1_q <= '0;
            i2_q <= '0;
            i3_q <= '0;
            ones_q <= '0;
        end
        else if (run)
        begin
            samp_q <= conv_end ? 14'h0000 : samp_q + 14'h0001;
            i1_q <= i1_d;
            i2_q <= i2_d;
            i3_q <= i3_d;
            ones_q <= conv_end ? 15'h0000 : ones_d;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            z1_q <= '0;
            z2_q <= '0;
            z3_q <= '0;
            acc_q <= '0;
        end
        else if (CLK_EN && cfg_q.standby)
        begin
            z1_q <= '0;
            z2_q <= '0;
            z3_q <= '0;
            acc_q <= '0;
        end
        else if (run && n3_end)
        begin
            z1_q <= i3_d;
            z2_q <= y1;
            z3_q <= y2;
            acc_q <= conv_end ? 21'h00_0000 : acc_d; // RQ11
        end
    end

    // Only a reset brings the fast path back.
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            fast_q <= 1'b1;
            first_q <= 1'b0;
        end
        else if (conv_push && fast_q)
        begin
            first_q <= 1'b1;
            fast_q <= !first_q; // RQ10
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The modulator cannot be held off, so a full FIFO drops the word and flags it.
    sync_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(MCLK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .in_valid(conv_push),
        .in_ready(fifo_in_ready),
        .in_data(word),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            cfg_q <= CFG_RST;
            ovf_q <= 1'b0;
            div_q <= DIV_HR;
            dv_q <= 1'b0;
        end
        else if (CLK_EN)
        begin
            if (wr_cfg)
                cfg_q <= cfg_s'(HWDATA[6:0]);
            if (conv_push && !fifo_in_ready)
                ovf_q <= 1'b1;
            else if (wr_st && HWDATA[ST_OVF_BIT])
                ovf_q <= 1'b0;
            div_q <= div_d; // RQ12
            dv_q <= fifo_out_valid;
        end
    end

    // Reads insert one wait state so a write just before them is visible.
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            hready_q <= 1'b1;
            rd_pend_q <= 1'b0;
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end
        else if (CLK_EN)
        begin
            rd_pend_q <= rd_acc;
            wr_pend_q <= acc && HWRITE;
            if (acc)
                addr_q <= HADDR[7:0];
            if (rd_acc)
                hready_q <= 1'b0;
            else if (rd_pend_q)
                hready_q <= 1'b1;
            if (rd_pend_q)
                hrdata_q <= rdata;
        end
    end

    assign HRDATA = hrdata_q;
    assign HREADYOUT = hready_q;
    assign HRESP = 1'b0;
    assign MOD_CLK = mod_ph_q;
    assign CLK_SRC_SEL = cfg_q.clk_sel;
    assign PWR_MODE = cfg_q.pwr;
    assign CLK_DIV = div_q;
    assign FAST_PATH = fast_q;
    assign DATA_VALID = dv_q;

    ////////////////////////////////////////////////////////////////////////////
    // Helper counters that only the checks below read.
    logic [13:0] span_q;
    logic [4:0] blk_q;
    logic [1:0] nconv_q;
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            span_q <= '0;
            blk_q <= '0;
            nconv_q <= '0;
        end
        else if (CLK_EN && cfg_q.standby)
        begin
            span_q <= '0;
            blk_q <= '0;
        end
        else if (run)
        begin
            span_q <= conv_end ? 14'h0000 : span_q + 14'h0001;
            if (n3_end)
                blk_q <= conv_end ? 5'h00 : blk_q + 5'h01;
            if (conv_end && nconv_q != 2'h3)
                nconv_q <= nconv_q + 2'h1;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    a_mod_clk_half: assert property (CLK_EN && !SYS_RST |=> MOD_CLK != $past(MOD_CLK)) // RQ4
        else $error("modulator clock does not toggle every enabled edge");
    a_conv_span: assert property (conv_push |-> span_q == 14'(osr - 15'h0001)) // RQ5 RQ6 RQ13
        else $error("conversion length differs from the selected ratio");
    a_rate_halves: assert property (conv_push |-> osr == 15'(1 << (OSR_MIN_LOG + int'(cfg_q.ratio)))) // RQ7
        else $error("ratio does not double per code step");
    a_sinc1_blocks: assert property (conv_push && n3_end |-> blk_q == 5'((5'h01 << d_log) - 5'h01)) // RQ11
        else $error("sinc1 stage block count wrong");
    a_fast_first: assert property (fast_q == (nconv_q < 2'h2)) // RQ9
        else $error("fast path not used for exactly two conversions");
    a_sinc_stays: assert property (!fast_q |=> !fast_q) // RQ10
        else $error("fast path reselected without reset");
    a_path_word: assert property (conv_push && fast_q |-> word == fast_out) // RQ8
        else $error("fast word not taken while fast path selected");
    a_div_map: assert property (CLK_EN && cfg_q.pwr == PWR_VLP |=> CLK_DIV == DIV_VLP) // RQ12
        else $error("very low power divider wrong");
    a_read_wait: assert property (rd_acc |=> !HREADYOUT ##1 (HREADYOUT || !$past(CLK_EN)))
        else $error("read wait state missing");

    c_path_switch: cover property (fast_q ##1 !fast_q);
    c_overflow: cover property (conv_push && !fifo_in_ready);
    c_data_read: cover property (pop && fifo_out_valid);
endmodule

//--- test/mod_stream_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Behavioural modulator stream: mode 0 all ones, 1 all zeros, 2 alternating.
module mod_stream_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic mod_clk,
    input wire logic [1:0] mode,
    output logic bit_out
);
    // The bit moves only after a sampling edge, so the filter never sees it mid-change.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            bit_out <= (mode == 2'd0);
        else if (mod_clk)
            bit_out <= (mode == 2'd0) ? 1'b1 : ((mode == 2'd1) ? 1'b0 : ~bit_out);
    end
endmodule

//--- test/decimation_filter_path_select_tb_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module decimation_filter_path_select_tb_top;
    import decim_pkg::*;
    logic MCLK, SYS_RST, CLK_EN, MOD_BIT, HSEL, HWRITE, HREADYOUT, HRESP;
    logic MOD_CLK, CLK_SRC_SEL, FAST_PATH, DATA_VALID, m;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0] HTRANS, PWR_MODE, mode;
    logic [2:0] HSIZE, CLK_DIV;
    int n_errors, cmp_count, cyc, t1, t2;

    decim_filter #(.FIFO_DEPTH(8)) u_dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .MOD_BIT(MOD_BIT),
        .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MOD_CLK(MOD_CLK),
        .CLK_SRC_SEL(CLK_SRC_SEL), .PWR_MODE(PWR_MODE), .CLK_DIV(CLK_DIV), .FAST_PATH(FAST_PATH),
        .DATA_VALID(DATA_VALID));
    mod_stream_model u_mod (.clk(MCLK), .rst(SYS_RST), .mod_clk(MOD_CLK), .mode(mode), .bit_out(MOD_BIT));

    initial
    begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    always @(posedge MCLK) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////////
    // One AHB-Lite single transfer; read data lands in rd.
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        HADDR <= {24'h00_0000, a};
        HWRITE <= w;
        HTRANS <= 2'b10;
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'b00;
        HWDATA <= wd;
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Waits for the FIFO to go from empty to holding a word; t is that cycle.
    task wait_word(output int t);
        int k;
        k = 0;
        while (DATA_VALID === 1'b1) @(posedge MCLK);
        while (DATA_VALID !== 1'b1 && k < 40000)
        begin
            @(posedge MCLK);
            k++;
        end
        chk({31'h0000_0000, DATA_VALID}, 32'h0000_0001);
        t = cyc;
    endtask

    task finish_test;
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #1_000_000;
        n_errors++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 32'h0000_0000, 32'h0000_0001);
        finish_test();
    end

    initial
    begin
        SYS_RST = 1'b1;
        CLK_EN = 1'b1;
        HSEL = 1'b1;
        HSIZE = 3'h2;
        HTRANS = 2'b00;
        HWRITE = 1'b0;
        HADDR = 32'h0000_0000;
        HWDATA = 32'h0000_0000;
        mode = 2'd0;
        n_errors = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (12) @(posedge MCLK);
        SYS_RST <= 1'b0;
        @(posedge MCLK);
        chk({22'h00_0000, HREADYOUT, HRESP, FAST_PATH, DATA_VALID, CLK_SRC_SEL, PWR_MODE, CLK_DIV},
            32'h0000_0281);
        ahb(1'b0, ADDR_CFG, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        ahb(1'b0, 8'h10, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        m = MOD_CLK;
        @(posedge MCLK);
        chk({31'h0000_0000, MOD_CLK}, {31'h0000_0000, ~m});
        CLK_EN <= 1'b0;
        @(posedge MCLK);
        m = MOD_CLK;
        repeat (2) @(posedge MCLK);
        chk({31'h0000_0000, MOD_CLK}, {31'h0000_0000, m});
        CLK_EN <= 1'b1;
        $display("test reset done");

        // Two fast conversions at full density, then the path must hand over.
        wait_word(t1);
        ahb(1'b0, ADDR_DATA, 32'h0000_0000);
        chk(rd, 32'h0001_0000);
        chk({31'h0000_0000, FAST_PATH}, 32'h0000_0001);
        wait_word(t2);
        ahb(1'b0, ADDR_DATA, 32'h0000_0000);
        chk(rd, 32'h0001_0000);
        chk(32'(t2 - t1), 32'h0000_0100);
        chk({31'h0000_0000, FAST_PATH}, 32'h0000_0000);
        // Five words let the sinc3 pipeline flush the previous density.
        for (int i = 1; i < 3; i++)
        begin
            mode <= 2'(i);
            repeat (5)
            begin
                wait_word(t1);
                ahb(1'b0, ADDR_DATA, 32'h0000_0000);
            end
            chk(rd, (i == 2) ? 32'h0000_8000 : 32'h0000_0000);
        end
        ahb(1'b1, ADDR_CFG, 32'h0000_0040);
        ahb(1'b1, ADDR_CFG, 32'h0000_0000);
        ahb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk({31'h0000_0000, FAST_PATH, rd[ST_FAST_BIT]}, 32'h0000_0000);
        $display("test path done");

        // Clock source and power mode change only while in standby.
        ahb(1'b1, ADDR_CFG, 32'h0000_0040);
        for (int p = 0; p < 3; p++)
        begin
            ahb(1'b1, ADDR_CFG, 32'h0000_0040 | (p << 3));
            repeat (2) @(posedge MCLK);
            chk({27'h000_0000, PWR_MODE, CLK_DIV}, {27'h000_0000, 2'(p), 3'(1 << p)});
        end
        ahb(1'b1, ADDR_CFG, 32'h0000_0060);
        ahb(1'b0, ADDR_CFG, 32'h0000_0000);
        chk({rd[30:0], CLK_SRC_SEL}, 32'h0000_00c1);
        ahb(1'b1, ADDR_CFG, 32'h0000_0040);
        $display("test clocking done");

        // The word spacing must double with each ratio code from 0 to 5; codes 6 and 7 are only read back.
        for (int c = 0; c < 8; c++)
        begin
            ahb(1'b1, ADDR_CFG, 32'(c));
            ahb(1'b0, ADDR_CFG, 32'h0000_0000);
            chk(rd, 32'(c));
            if (c < 6)
            begin
                repeat (2)
                begin
                    wait_word(t1);
                    ahb(1'b0, ADDR_DATA, 32'h0000_0000);
                end
                wait_word(t2);
                ahb(1'b0, ADDR_DATA, 32'h0000_0000);
                chk(32'(t2 - t1), 32'(256 << c));
            end
        end
        $display("test ratio done");

        // Standby restarts the filter so the overflow run starts from a known count.
        ahb(1'b1, ADDR_CFG, 32'h0000_0040);
        ahb(1'b1, ADDR_CFG, 32'h0000_0000);
        repeat (3000) @(posedge MCLK);
        ahb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk(rd & 32'h0000_0fff, 32'h0000_0806);
        ahb(1'b1, ADDR_CFG, 32'h0000_0040);
        repeat (8) ahb(1'b0, ADDR_DATA, 32'h0000_0000);
        ahb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk(rd & 32'h0000_0fff, 32'h0000_0002);
        ahb(1'b1, ADDR_STATUS, 32'h0000_0002);
        ahb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk(rd & 32'h0000_0fff, 32'h0000_0000);
        chk({31'h0000_0000, DATA_VALID}, 32'h0000_0000);
        $display("test fifo done");

        // A second reset re-arms the fast path; with the external clock pin grounded,
        // the oscillator may be chosen straight after reset without standby.
        SYS_RST <= 1'b1;
        repeat (2) @(posedge MCLK);
        SYS_RST <= 1'b0;
        @(posedge MCLK);
        chk({31'h0000_0000, FAST_PATH}, 32'h0000_0001);
        ahb(1'b1, ADDR_CFG, 32'h0000_0020);
        ahb(1'b0, ADDR_CFG, 32'h0000_0000);
        chk({rd[30:0], CLK_SRC_SEL}, 32'h0000_0041);
        $display("test rearm done");
        finish_test();
    end
endmodule
